// ===== rtl/nvac_ctrl.sv
// Data store access control: address, data, control, unlock and status registers
// in front of a 256-byte byte-writable store, with a timed, unlocked write cycle.
// Assumes a single 100 MHz clock, synchronous active-low reset and a register
// master that never asserts both strobes together.
//
// The implementer's own choices: strobed register access and the address map.
`include "nvac_map.svh"

module nvac_ctrl #(
    parameter int WRITE_CYCLES =
        (`NVAC_WRITE_TIME_NS + `NVAC_CLK_PERIOD_NS - 1) / `NVAC_CLK_PERIOD_NS
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  clkEn,
    input  wire nvac_pkg::nvac_bus_req_t busReq,
    output logic [7:0]                 rdData,
    output logic                       writeBusy,
    output logic                       writeDone
);
    import nvac_pkg::*;

    nvac_state_t st_reg;
    nvac_state_t st_next;
    nvac_state_t rstState;

    logic       anyAccess;
    logic       ctlWrite;
    logic       readTrig;
    logic       dataWrite;
    logic       startWrite;
    logic       finishWrite;
    logic [7:0] readByte;
    logic [7:0] rdMux;

    // Decode of the current request; clock enable low makes it invisible
    assign anyAccess   = clkEn && (busReq.wrStb || busReq.rdStb);
    assign ctlWrite    = clkEn && busReq.wrStb && busReq.addr == `NVAC_OFS_CONTROL;
    assign dataWrite   = clkEn && busReq.wrStb && busReq.addr == `NVAC_OFS_DATA_LOW;
    assign readTrig    = ctlWrite && busReq.wdata[`NVAC_CTL_RD]
                         && !busReq.wdata[`NVAC_CTL_SPACE];
    assign startWrite  = ctlWrite && st_reg.unlock == NVAC_ARMED
                         && busReq.wdata[`NVAC_CTL_WR] && st_reg.write_enable_bit
                         && !busReq.wdata[`NVAC_CTL_SPACE] && !st_reg.wrBusy;
    assign finishWrite = clkEn && st_reg.wrBusy && st_reg.timer == `NVAC_TIMER_W'(1);
    assign readByte    = st_reg.mem[st_reg.addrLow];

    // Read-back mux; unmapped offsets answer zero
    always_comb begin
        rdMux = `NVAC_RST_BYTE;
        case (busReq.addr)
            `NVAC_OFS_ADDR_LOW: rdMux = st_reg.addrLow;
            `NVAC_OFS_DATA_LOW: rdMux = st_reg.dataLow;
            `NVAC_OFS_CONTROL:  rdMux = {st_reg.spaceSel, 3'h0, st_reg.abortFlag,
                                         st_reg.write_enable_bit, st_reg.wrBusy, 1'b0};
            `NVAC_OFS_UNLOCK:   rdMux = `NVAC_RST_BYTE;
            `NVAC_OFS_STATUS:   rdMux = {7'h00, st_reg.doneFlag};
            default:            rdMux = `NVAC_RST_BYTE;
        endcase
    end

    // Next-state of the whole block
    always_comb begin
        st_next = st_reg;
        // Read data stands only in the cycle after the strobe
        st_next.rdData = (clkEn && busReq.rdStb) ? rdMux : `NVAC_RST_BYTE;

        if (clkEn && busReq.wrStb && busReq.addr == `NVAC_OFS_ADDR_LOW) begin
            st_next.addrLow = busReq.wdata;
        end
        if (dataWrite) begin
            st_next.dataLow = busReq.wdata;
        end
        if (ctlWrite) begin
            st_next.spaceSel  = busReq.wdata[`NVAC_CTL_SPACE];
            st_next.write_enable_bit      = busReq.wdata[`NVAC_CTL_WRITE_ENABLE_BIT];
            st_next.abortFlag = busReq.wdata[`NVAC_CTL_ABORT];
        end
        if (readTrig) begin
            st_next.dataLow = readByte;
        end

        if (anyAccess) begin
            case (st_reg.unlock)
                NVAC_LOCKED,
                NVAC_KEY1: begin
                    if (busReq.wrStb && busReq.addr == `NVAC_OFS_UNLOCK
                        && busReq.wdata == `NVAC_KEY_FIRST) begin
                        st_next.unlock = NVAC_KEY1;
                    end else if (st_reg.unlock == NVAC_KEY1 && busReq.wrStb
                        && busReq.addr == `NVAC_OFS_UNLOCK
                        && busReq.wdata == `NVAC_KEY_SECOND) begin
                        st_next.unlock = NVAC_ARMED;
                    end else begin
                        st_next.unlock = NVAC_LOCKED;
                    end
                end
                default: st_next.unlock = NVAC_LOCKED; // Armed is spent by any access
            endcase
        end

        // write runs on latched copies, blind to write-enable
        if (startWrite) begin
            st_next.wrBusy = 1'b1;
            st_next.timer  = `NVAC_TIMER_W'(WRITE_CYCLES);
            st_next.wrAddr = st_reg.addrLow;
            st_next.wrByte = st_reg.dataLow;
        end else if (clkEn && st_reg.wrBusy) begin
            st_next.timer = st_reg.timer - `NVAC_TIMER_W'(1);
        end

        if (clkEn && busReq.wrStb && busReq.addr == `NVAC_OFS_STATUS
            && !busReq.wdata[`NVAC_STS_DONE]) begin
            st_next.doneFlag = 1'b0;
        end
        if (finishWrite) begin
            st_next.wrBusy             = 1'b0;
            st_next.doneFlag           = 1'b1;
            st_next.mem[st_reg.wrAddr] = st_reg.wrByte;
        end
    end

    // Reset image: store keeps contents, registers clear except abort, which a write in progress sets and which otherwise holds
    always_comb begin
        rstState           = '0;
        rstState.mem       = st_reg.mem;
        rstState.unlock    = NVAC_LOCKED;
        rstState.abortFlag = st_reg.wrBusy | st_reg.abortFlag;
    end

    // State register; reset is synchronous so the image may read state
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= rstState;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign rdData    = st_reg.rdData;
    assign writeBusy = st_reg.wrBusy;
    assign writeDone = st_reg.doneFlag;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence readReq_s;
        readTrig;
    endsequence
    sequence writeStart_s;
        $rose(st_reg.wrBusy);
    endsequence

    read_next_a: assert property (readReq_s |=> st_reg.dataLow == $past(readByte))
        else $error("read byte not in data register next cycle");
    data_hold_a: assert property ($changed(st_reg.dataLow) |-> $past(readTrig || dataWrite))
        else $error("data register changed without cause");
    wr_enable_a: assert property (writeStart_s |-> $past(st_reg.write_enable_bit))
        else $error("write started without write-enable");
    write_enable_bit_owner_a: assert property ($changed(st_reg.write_enable_bit) |-> $past(ctlWrite))
        else $error("write-enable moved without software");
    unlock_start_a: assert property (writeStart_s |-> $past(st_reg.unlock) == NVAC_ARMED)
        else $error("write started without unlock");
    write_time_a: assert property (writeStart_s |-> st_reg.timer == `NVAC_TIMER_W'(WRITE_CYCLES)
                                  ##1 st_reg.wrBusy)
        else $error("write period not loaded");
    done_set_a: assert property (finishWrite |=> !st_reg.wrBusy && st_reg.doneFlag)
        else $error("completion did not clear busy and set flag");
    mem_update_a: assert property (finishWrite |=> st_reg.mem[$past(st_reg.wrAddr)]
                                   == $past(st_reg.wrByte))
        else $error("byte not stored at completion");
    flag_sticky_a: assert property ($fell(st_reg.doneFlag) |-> $past(clkEn && busReq.wrStb
                                    && busReq.addr == `NVAC_OFS_STATUS))
        else $error("done flag cleared by hardware");
    unlock_zero_a: assert property (clkEn && busReq.rdStb && busReq.addr == `NVAC_OFS_UNLOCK
                                    |=> rdData == `NVAC_RST_BYTE)
        else $error("unlock port read non-zero");
    abort_mark_a: assert property (disable iff (1'b0) !resetn && st_reg.wrBusy
                                   |=> st_reg.abortFlag)
        else $error("reset during write not flagged");

endmodule : nvac_ctrl

// ===== rtl/nvac_map.svh
// Register offsets, bit positions, reset values and timing for the data store access block.
// Assumes a 100 MHz core clock and an 8-bit register port with 4-bit offsets.
`ifndef NVAC_MAP_SVH
`define NVAC_MAP_SVH

// Register offsets on the register port
`define NVAC_OFS_ADDR_LOW    4'h0
`define NVAC_OFS_DATA_LOW    4'h1
`define NVAC_OFS_CONTROL     4'h2
`define NVAC_OFS_UNLOCK      4'h3
`define NVAC_OFS_STATUS      4'h4

// Bit positions in the control register
`define NVAC_CTL_SPACE       7
`define NVAC_CTL_ABORT       3
`define NVAC_CTL_WRITE_ENABLE_BIT        2
`define NVAC_CTL_WR          1
`define NVAC_CTL_RD          0
// Bit position in the status register
`define NVAC_STS_DONE        0

// Unlock keys, in order
`define NVAC_KEY_FIRST       8'h55
`define NVAC_KEY_SECOND      8'haa

// Reset values
`define NVAC_RST_BYTE        8'h00

// Memory size and write timing
`define NVAC_MEM_DEPTH       256
`define NVAC_CLK_PERIOD_NS   10
`define NVAC_WRITE_TIME_NS   4000000
`define NVAC_TIMER_W         20

`endif

// ===== rtl/nvac_pkg.sv
// Types for the data store access block: bus request carrier, unlock states, block state.
// Assumes nvac_map.svh supplies the memory depth.
`include "nvac_map.svh"

package nvac_pkg;

    // One register-port request, all signals that travel together
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wrStb;
        logic       rdStb;
    } nvac_bus_req_t;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        NVAC_LOCKED = 2'b00,
        NVAC_KEY1   = 2'b01,
        NVAC_ARMED  = 2'b10
    } nvac_unlock_t;

    // Whole state of the block
    typedef struct packed {
        logic [`NVAC_MEM_DEPTH-1:0][7:0] mem;
        logic [7:0]                      addrLow;
        logic [7:0]                      dataLow;
        logic                            spaceSel;
        logic                            write_enable_bit;
        logic                            abortFlag;
        logic                            doneFlag;
        logic                            wrBusy;
        logic [`NVAC_TIMER_W-1:0]        timer;
        logic [7:0]                      wrAddr;
        logic [7:0]                      wrByte;
        nvac_unlock_t                    unlock;
        logic [7:0]                      rdData;
    } nvac_state_t;

endpackage : nvac_pkg

// ===== verif/tb.sv
// Self-checking bench for the data store access block, one task per scenario.
// Assumes nvac_ctrl with a short write time and a register master that never waits.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvac_pkg::*;

    localparam int WC = 8;   // Short write time keeps the run brief

    logic          sys_clk;
    logic          resetn;
    logic          clkEn;
    logic          writeBusy;
    logic          writeDone;
    logic [7:0]    rdData;
    nvac_bus_req_t busReq;
    int            failCount = 0;
    int            totalChecks = 0;
    int            cyc = 0;

    nvac_ctrl #(.WRITE_CYCLES(WC)) i_nvac_ctrl (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .clkEn     (clkEn),
        .busReq    (busReq),
        .rdData    (rdData),
        .writeBusy (writeBusy),
        .writeDone (writeDone)
    );

    // Free-running core clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cycle ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 3000) begin
            failCount++;
            finishTest();
        end
    end

    task automatic finishTest();
        $display("checks=%0d errors=%0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finishTest

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Whole request changes right after an edge
    task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wrStb: w, rdStb: r};
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, d, 1'b1, 1'b0);
    endtask : wr

    // Release strobes, then look once the edge has landed
    task automatic idle();
        bus(4'h0, 8'h00, 1'b0, 1'b0);
        #1;
    endtask : idle

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        bus(a, 8'h00, 1'b0, 1'b1);
        idle();
        chk(rdData, exp);
    endtask : rd

    // Load address and data, then the exact unlock sequence
    task automatic arm(input logic [7:0] a, input logic [7:0] d);
        wr(4'h0, a);
        wr(4'h1, d);
        wr(4'h2, 8'h04);
        wr(4'h3, 8'h55);
        wr(4'h3, 8'haa);
        wr(4'h2, 8'h06);
        idle();
    endtask : arm

    task automatic testReset();
        wr(4'h2, 8'h00);    // Abort bit may be unknown at power-up
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h5, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h1, 8'h00);
    endtask : testReset

    task automatic testWrite(input logic [7:0] a, input logic [7:0] d);
        int n;
        chk({7'h0, writeBusy}, 8'h00);
        wr(4'h4, 8'h00);
        arm(a, d);
        chk({7'h0, writeBusy}, 8'h01);
        wr(4'h2, 8'h00);
        idle();
        n = 2;
        while (writeBusy === 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(8'(n), 8'(WC));
        chk({6'h0, writeBusy, writeDone}, 8'h01);
    endtask : testWrite

    task automatic testRead(input logic [7:0] a, input logic [7:0] exp);
        wr(4'h0, a);
        wr(4'h2, 8'h01);
        rd(4'h1, exp);
        @(posedge sys_clk);
        #1;
        chk(rdData, 8'h00);
        wr(4'h0, a ^ 8'h01);
        rd(4'h1, exp);
    endtask : testRead

    task automatic testSticky();
        repeat (5) @(posedge sys_clk);
        rd(4'h4, 8'h01);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h00);
    endtask : testSticky

    task automatic testRefuse();
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h55);
        wr(4'h3, 8'haa);
        wr(4'h2, 8'h02);
        idle();
        chk({7'h0, writeBusy}, 8'h00);
        wr(4'h2, 8'h04);
        wr(4'h3, 8'h55);
        bus(4'h4, 8'h00, 1'b0, 1'b1);
        wr(4'h3, 8'haa);
        wr(4'h2, 8'h06);
        idle();
        chk({7'h0, writeBusy}, 8'h00);
        wr(4'h3, 8'haa);
        wr(4'h3, 8'h55);
        wr(4'h2, 8'h06);
        idle();
        chk({7'h0, writeBusy}, 8'h00);
        rd(4'h2, 8'h04);
    endtask : testRefuse

    // Clock enable low swallows strobes and freezes state
    task automatic testHold();
        wr(4'h0, 8'h33);
        bus(4'h0, 8'h00, 1'b0, 1'b0);
        clkEn <= 1'b0;
        wr(4'h0, 8'h5a);
        bus(4'h0, 8'h00, 1'b0, 1'b0);
        clkEn <= 1'b1;
        rd(4'h0, 8'h33);
    endtask : testHold

    // Reset in mid-write must leave the abort bit behind
    task automatic testAbort();
        arm(8'h10, 8'h77);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(4'h2, 8'h08);
        chk({6'h0, writeBusy, writeDone}, 8'h00);
        rd(4'h0, 8'h00);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h00);
    endtask : testAbort

    // Main sequence, six reset cycles first
    initial begin
        clkEn  = 1'b1;
        resetn = 1'b0;
        busReq = '0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        testReset();
        testWrite(8'h00, 8'h3c);
        testRead(8'h00, 8'h3c);
        testWrite(8'hff, 8'ha5);
        testWrite(8'hff, 8'h5a);
        testRead(8'hff, 8'h5a);
        testSticky();
        testRefuse();
        testHold();
        testAbort();
        finishTest();
    end
endmodule : tb
